// ===== hdl/down_timer.sv
// Purpose: One 8-bit down counter with its 6-bit prescaler
// Assumes: tick is a one-cycle pulse of the source clock
// Notes: Prescaler state is internal and never read back
`timescale 1ns/100ps
module down_timer (
  input wire logic clock_in,
  input wire logic resetn_in,
  timer_link_if.unit link
);
  logic [5:0] prescale_count; // Source pulses left in this period
  logic [7:0] count; // Counter value
  logic stopped; // Single pass reached zero
  logic expired; // End-of-count pulse

  assign link.count = count;
  assign link.expired = expired;
  assign link.stopped = stopped;

  // ---------------------------------------------------------------
  // Prescaler and counter
  // ---------------------------------------------------------------
  // Divide 1..64 by counting down from the programmed value to one; zero
  // wraps to 64 because the count wraps to 63 and reaches one after 63 decrements
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prescale_count <= 6'h00;
      count <= 8'h00;
      stopped <= 1'b1;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (link.load) begin
        // Restart from the initial value
        prescale_count <= link.prescale;
        count <= link.initial_value;
        stopped <= 1'b0;
      end else if (link.enable && !stopped && link.tick) begin
        if (prescale_count == 6'h01) begin
          prescale_count <= link.prescale;
          // Counter steps once per prescaler period
          count <= count - 8'h01;
          if (count == 8'h01) begin
            expired <= 1'b1;
            if (link.continuous) begin
              count <= link.initial_value;
            end else begin
              stopped <= 1'b1;
            end
          end
        end else begin
          prescale_count <= prescale_count - 6'h01;
        end
      end
    end
  end
endmodule // down_timer

// ===== hdl/timer_link_if.sv
// Purpose: Carries setup and status between controller and one timer
// Assumes: One clock domain
// Notes: The controller owns setup, the timer owns count and expiry
`timescale 1ns/100ps
interface timer_link_if;
  logic tick; // Source clock pulse into the prescaler
  logic load; // Restart from initial value
  logic enable; // Counting allowed
  logic continuous; // Reload at zero instead of stopping
  logic [7:0] initial_value; // Initial count, zero means 256
  logic [5:0] prescale; // Divide value, zero means 64
  logic [7:0] count; // Present count
  logic expired; // One-cycle end-of-count pulse
  logic stopped; // Single pass finished

  modport ctrl (output tick, load, enable, continuous, initial_value, prescale,
    input count, expired, stopped);
  modport unit (input tick, load, enable, continuous, initial_value, prescale,
    output count, expired, stopped);
endinterface

// ===== hdl/vectored_interrupt_and_timers.sv
// Purpose: Six prioritised vectored interrupt requests and two timers
// Assumes: Pins, comparators and coprocessor request are synchronous
// Notes: The processor performs the stacking; this block starts it
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/100ps
module vectored_interrupt_and_timers (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] address_in,
  input wire logic [7:0] write_data_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] read_data_out,
  input wire logic port_three_line_a_in,
  input wire logic port_three_line_b_in,
  input wire logic port_three_line_c_in,
  input wire logic comparator_one_input_in,
  input wire logic comparator_two_input_in,
  input wire logic coprocessor_request_in,
  input wire logic halt_in,
  output logic interrupt_cycle_out,
  output logic [7:0] vector_address_out,
  output logic wake_out
);
  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Rotating priority: search starts at the programmed request
  function automatic logic [2:0] pick_request(input logic [5:0] pending,
    input logic [2:0] first);
    logic [2:0] chosen;
    logic found;
    logic [2:0] idx;
    chosen = 3'h0;
    found = 1'b0;
    idx = (first > 3'h5) ? 3'h0 : first;
    for (int i = 0; i < vit_pkg::NUM_REQ; i++) begin
      if (!found && pending[idx]) begin
        chosen = idx;
        found = 1'b1;
      end
      idx = (idx == 3'h5) ? 3'h0 : idx + 3'h1;
    end
    return chosen;
  endfunction

  // Write strobe aimed at one register
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
    input logic [7:0] offset);
    return strobe && (addr == offset);
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] interrupt_mask_register; // Bit 7 global, 5:0 per request
  logic [7:0] interrupt_priority_register; // Bits 2:0 first request
  logic [5:0] request_flags; // Pending requests
  logic [1:0] edge_select; // Bits 7,6 of request register
  logic [7:0] timer_mode_register; // Timer control and input mode
  logic [7:0] t0_prescale_reg; // Timer zero prescaler setup
  logic [7:0] t1_prescale_reg; // Timer one prescaler setup
  logic [7:0] t0_initial; // Timer zero initial value
  logic [7:0] t1_initial; // Timer one initial value
  logic analog_select; // Comparators replace lines a and b
  logic t0_load; // Restart pulse for timer zero
  logic t1_soft_load; // Restart pulse for timer one from software
  logic [1:0] div_count; // Internal clock divide-by-four
  logic div_tick; // One pulse every fourth clock
  logic [7:0] read_data; // Registered read answer
  logic interrupt_cycle; // Grant pulse
  logic [7:0] vector_address; // Vector byte address
  logic wake; // Halt release

  // Previous samples for edge detection
  logic prev_a, prev_b, prev_c, prev_coproc;
  logic next_src_a, next_src_b; // Selected sources for lines a and b
  logic rise_a, fall_a, rise_b, fall_b, fall_c, fall_coproc;
  logic [5:0] set_events; // Edges and timer ends this cycle
  logic [5:0] enabled_pending; // Pending and individually enabled
  logic grant; // Grant this cycle
  logic [2:0] granted_index; // Which request is granted
  logic [5:0] grant_clear; // Flag cleared by the grant
  logic mask_write; // Software writes the mask register

  timer_link_if t0_link ();
  timer_link_if t1_link ();

  assign read_data_out = read_data;
  assign interrupt_cycle_out = interrupt_cycle;
  assign vector_address_out = vector_address;
  assign wake_out = wake;

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  // Comparator outputs take the pin's place when analog is selected
  assign next_src_a = analog_select ? comparator_one_input_in : port_three_line_a_in;
  assign next_src_b = analog_select ? comparator_two_input_in : port_three_line_b_in;

  // Sample every source once per clock for a synchronous compare
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      prev_c <= 1'b0;
      prev_coproc <= 1'b0;
    end else begin
      prev_a <= next_src_a;
      prev_b <= next_src_b;
      prev_c <= port_three_line_c_in;
      prev_coproc <= coprocessor_request_in;
    end
  end

  assign rise_a = next_src_a && !prev_a;
  assign fall_a = !next_src_a && prev_a;
  assign rise_b = next_src_b && !prev_b;
  assign fall_b = !next_src_b && prev_b;
  assign fall_c = !port_three_line_c_in && prev_c;
  assign fall_coproc = !coprocessor_request_in && prev_coproc;

  // Edge choice: 00 fall/fall, 01 a fall b rise, 10 a rise b fall, 11 both
  always_comb begin
    set_events = 6'h00;
    set_events[vit_pkg::REQ_PIN_A] = (edge_select[1] && rise_a) ||
      ((!edge_select[1] || edge_select[0]) && fall_a);
    set_events[vit_pkg::REQ_PIN_B] = (edge_select[0] && rise_b) ||
      ((!edge_select[0] || edge_select[1]) && fall_b);
    set_events[vit_pkg::REQ_PIN_C] = fall_c;
    set_events[vit_pkg::REQ_COPROC] = fall_coproc;
    set_events[vit_pkg::REQ_TIMER0] = t0_link.expired;
    set_events[vit_pkg::REQ_TIMER1] = t1_link.expired;
  end

  // ---------------------------------------------------------------
  // Priority and grant
  // ---------------------------------------------------------------
  assign enabled_pending = request_flags & interrupt_mask_register[5:0];
  // One grant at a time; a grant clears the global enable at once
  assign grant = interrupt_mask_register[vit_pkg::MASK_GLOBAL_BIT] &&
    (|enabled_pending) && !interrupt_cycle;
  assign granted_index = pick_request(enabled_pending, interrupt_priority_register[2:0]);
  assign grant_clear = grant ? (6'h01 << granted_index) : 6'h00;
  assign mask_write = hit(write_in, address_in, vit_pkg::OFS_MASK);

  // Start the interrupt machine cycle and present the vector location
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      interrupt_cycle <= 1'b0;
      vector_address <= vit_pkg::RESET_BYTE;
    end else begin
      interrupt_cycle <= grant;
      if (grant) begin
        vector_address <= {4'h0, granted_index, 1'b0};
      end
    end
  end

  // Halt release on any enabled request, including masked-off global
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wake <= 1'b0;
    end else begin
      wake <= halt_in && (|enabled_pending);
    end
  end

  // ---------------------------------------------------------------
  // Request flags
  // ---------------------------------------------------------------
  // Flags latch even while masked so software can poll them; a new
  // event wins over a software clear or a grant in the same cycle
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      request_flags <= 6'h00;
      edge_select <= 2'h0;
    end else begin
      if (hit(write_in, address_in, vit_pkg::OFS_REQUEST)) begin
        edge_select <= write_data_in[vit_pkg::EDGE_A_BIT -: 2];
        request_flags <= write_data_in[5:0] | set_events;
      end else begin
        request_flags <= (request_flags & ~grant_clear) | set_events;
        if (hit(write_in, address_in, vit_pkg::OFS_COPROC_CTRL) &&
            write_data_in[vit_pkg::COPROC_CLEAR_BIT]) begin
          // Clear of coprocessor request; a new edge still wins
          request_flags[vit_pkg::REQ_COPROC] <= set_events[vit_pkg::REQ_COPROC];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Mask, priority and mode registers
  // ---------------------------------------------------------------
  // Grant drops the global enable; software sets it again when done
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      interrupt_mask_register <= vit_pkg::RESET_BYTE;
    end else if (mask_write) begin
      interrupt_mask_register <= write_data_in;
    end else if (grant) begin
      interrupt_mask_register[vit_pkg::MASK_GLOBAL_BIT] <= 1'b0;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      interrupt_priority_register <= vit_pkg::RESET_BYTE;
      analog_select <= 1'b0;
      t0_prescale_reg <= vit_pkg::RESET_BYTE;
      t1_prescale_reg <= vit_pkg::RESET_BYTE;
      t0_initial <= vit_pkg::RESET_BYTE;
      t1_initial <= vit_pkg::RESET_BYTE;
    end else if (write_in) begin
      unique case (address_in)
        vit_pkg::OFS_PRIORITY: interrupt_priority_register <= write_data_in;
        vit_pkg::OFS_INPUT_MODE: analog_select <= write_data_in[0];
        vit_pkg::OFS_T0_PRESCALE: t0_prescale_reg <= write_data_in;
        vit_pkg::OFS_T1_PRESCALE: t1_prescale_reg <= write_data_in;
        vit_pkg::OFS_T0_VALUE: t0_initial <= write_data_in;
        vit_pkg::OFS_T1_VALUE: t1_initial <= write_data_in;
        default: ; // Other offsets handled elsewhere or ignored
      endcase
    end
  end

  // Timer mode; load bits are self-clearing pulses
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timer_mode_register <= vit_pkg::RESET_BYTE;
      t0_load <= 1'b0;
      t1_soft_load <= 1'b0;
    end else begin
      t0_load <= 1'b0;
      t1_soft_load <= 1'b0;
      if (hit(write_in, address_in, vit_pkg::OFS_TIMER_MODE)) begin
        timer_mode_register <= write_data_in;
        t0_load <= write_data_in[vit_pkg::TMR_T0_LOAD_BIT];
        t1_soft_load <= write_data_in[vit_pkg::TMR_T1_LOAD_BIT];
        timer_mode_register[vit_pkg::TMR_T0_LOAD_BIT] <= 1'b0;
        timer_mode_register[vit_pkg::TMR_T1_LOAD_BIT] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Timer sources
  // ---------------------------------------------------------------
  // Internal timer clock is the processor clock divided by four
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_count <= 2'h0;
      div_tick <= 1'b0;
    end else begin
      div_count <= div_count + 2'h1;
      div_tick <= (div_count == vit_pkg::INT_CLOCK_DIV);
    end
  end

  vit_pkg::tin_mode_e tin_mode; // External input use
  logic t1_tick; // Source pulse for timer one
  logic t1_trigger; // Trigger-mode restart of timer one

  assign tin_mode = vit_pkg::tin_mode_e'(timer_mode_register[vit_pkg::TMR_TIN_LSB +: 2]);

  // Timer one source: cascade, internal (optionally gated) or line a
  always_comb begin
    t1_tick = div_tick;
    t1_trigger = 1'b0;
    if (timer_mode_register[vit_pkg::TMR_CASCADE_BIT]) begin
      t1_tick = t0_link.expired;
    end else if (!t1_prescale_reg[vit_pkg::PRE_INTERNAL_BIT]) begin
      unique case (tin_mode)
        vit_pkg::TIN_CLOCK: t1_tick = fall_a;
        vit_pkg::TIN_GATE: t1_tick = div_tick && next_src_a;
        vit_pkg::TIN_TRIGGER: t1_trigger = fall_a && t1_link.stopped;
        vit_pkg::TIN_RETRIGGER: t1_trigger = fall_a;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Timer instances
  // ---------------------------------------------------------------
  assign t0_link.tick = div_tick;
  assign t0_link.load = t0_load;
  assign t0_link.enable = timer_mode_register[vit_pkg::TMR_T0_ENABLE_BIT];
  assign t0_link.continuous = t0_prescale_reg[vit_pkg::PRE_CONT_BIT];
  assign t0_link.initial_value = t0_initial;
  assign t0_link.prescale = t0_prescale_reg[vit_pkg::PRE_DIV_LSB +: 6];

  assign t1_link.tick = t1_tick;
  assign t1_link.load = t1_soft_load || t1_trigger;
  assign t1_link.enable = timer_mode_register[vit_pkg::TMR_T1_ENABLE_BIT];
  assign t1_link.continuous = t1_prescale_reg[vit_pkg::PRE_CONT_BIT];
  assign t1_link.initial_value = t1_initial;
  assign t1_link.prescale = t1_prescale_reg[vit_pkg::PRE_DIV_LSB +: 6];

  down_timer timer_zero (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .link(t0_link)
  );

  down_timer timer_one (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .link(t1_link)
  );

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Answer stands one cycle after the strobe; prescalers read as zero
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      read_data <= vit_pkg::RESET_BYTE;
    end else if (read_in) begin
      unique case (address_in)
        vit_pkg::OFS_REQUEST: read_data <= {edge_select, request_flags};
        vit_pkg::OFS_MASK: read_data <= interrupt_mask_register;
        vit_pkg::OFS_PRIORITY: read_data <= interrupt_priority_register;
        vit_pkg::OFS_TIMER_MODE: read_data <= timer_mode_register;
        vit_pkg::OFS_INPUT_MODE: read_data <= {7'h00, analog_select};
        vit_pkg::OFS_T0_VALUE: read_data <= t0_link.count;
        vit_pkg::OFS_T1_VALUE: read_data <= t1_link.count;
        vit_pkg::OFS_COPROC_CTRL: read_data <= {7'h00, request_flags[vit_pkg::REQ_COPROC]};
        default: read_data <= vit_pkg::RESET_BYTE;
      endcase
    end else begin
      read_data <= vit_pkg::RESET_BYTE;
    end
  end
endmodule // vectored_interrupt_and_timers

// ===== hdl/vit_pkg.sv
// Purpose: Shared constants of the interrupt and counter/timer block
// Assumes: 8-bit register port, one system clock
// Notes: Offsets are register-file addresses of the control processor
package vit_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_INPUT_MODE = 8'hf0; // Comparator routing select
  localparam logic [7:0] OFS_TIMER_MODE = 8'hf1; // Timer mode register
  localparam logic [7:0] OFS_T1_VALUE = 8'hf2; // Timer one initial / count
  localparam logic [7:0] OFS_T1_PRESCALE = 8'hf3; // Timer one prescaler setup
  localparam logic [7:0] OFS_T0_VALUE = 8'hf4; // Timer zero initial / count
  localparam logic [7:0] OFS_T0_PRESCALE = 8'hf5; // Timer zero prescaler setup
  localparam logic [7:0] OFS_PRIORITY = 8'hf9; // Interrupt priority register
  localparam logic [7:0] OFS_REQUEST = 8'hfa; // Interrupt request flags
  localparam logic [7:0] OFS_MASK = 8'hfb; // Interrupt mask register
  localparam logic [7:0] OFS_COPROC_CTRL = 8'hfc; // Coprocessor control register

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int NUM_REQ = 6; // Number of interrupt requests
  localparam int REQ_PIN_B = 0; // Request from line b / comparator two
  localparam int REQ_PIN_C = 1; // Request from line c, falling only
  localparam int REQ_PIN_A = 2; // Request from line a / comparator one
  localparam int REQ_COPROC = 3; // Request from coprocessor
  localparam int REQ_TIMER0 = 4; // Timer zero end of count
  localparam int REQ_TIMER1 = 5; // Timer one end of count
  localparam int MASK_GLOBAL_BIT = 7; // Global enable in mask register
  localparam int EDGE_A_BIT = 7; // Edge select for line a
  localparam int EDGE_B_BIT = 6; // Edge select for line b
  localparam int TMR_T0_LOAD_BIT = 0; // Write 1: restart timer zero
  localparam int TMR_T0_ENABLE_BIT = 1; // Timer zero count enable
  localparam int TMR_T1_LOAD_BIT = 2; // Write 1: restart timer one
  localparam int TMR_T1_ENABLE_BIT = 3; // Timer one count enable
  localparam int TMR_TIN_LSB = 4; // External input mode, two bits
  localparam int TMR_CASCADE_BIT = 6; // Timer zero drives timer one
  localparam int PRE_CONT_BIT = 0; // Continuous (modulo-n) mode
  localparam int PRE_INTERNAL_BIT = 1; // Timer one internal source
  localparam int PRE_DIV_LSB = 2; // Six-bit divide value
  localparam int COPROC_CLEAR_BIT = 0; // Write 1 clears coprocessor request

  // ---------------------------------------------------------------
  // Reset values and timing counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RESET_BYTE = 8'h00; // Reset value of all registers
  localparam logic [1:0] INT_CLOCK_DIV = 2'h3; // Internal clock divided by four

  // External timer input modes
  typedef enum logic [1:0] {
    TIN_CLOCK, TIN_GATE, TIN_TRIGGER, TIN_RETRIGGER
  } tin_mode_e;
endpackage

// ===== test/vectored_interrupt_and_timers_bench.sv
// Purpose: Self-checking bench of the interrupt and timer block
// Assumes: 25 MHz clock, seed 6, partner model drives the pins
// Notes: Expectations are literals, loop-variable expressions or come from the bench function winner
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) fail(g, e); end
module vectored_interrupt_and_timers_bench;
  logic clock_in = 0, resetn_in = 0, write_in = 0, read_in = 0, halt_in = 0, cyc, wake;
  logic [7:0] address_in = 8'h00, write_data_in = 8'h00, rdata, flags, rdo, vec;
  logic [5:0] level = 6'h3f, line; // Commanded and driven pin levels
  int bad_count = 0, num_checks = 0, p, w;
  always #20 clock_in = ~clock_in;
  vit_partner pm (.clock_in(clock_in), .resetn_in(resetn_in), .level_in(level), .line_out(line));
  vectored_interrupt_and_timers uut (.clock_in(clock_in), .resetn_in(resetn_in),
    .address_in(address_in), .write_data_in(write_data_in), .write_in(write_in),
    .read_in(read_in), .read_data_out(rdo), .port_three_line_a_in(line[0]),
    .port_three_line_b_in(line[1]), .port_three_line_c_in(line[2]),
    .comparator_one_input_in(line[3]), .comparator_two_input_in(line[4]),
    .coprocessor_request_in(line[5]), .halt_in(halt_in), .interrupt_cycle_out(cyc),
    .vector_address_out(vec), .wake_out(wake));
  task automatic fail(input logic [7:0] g, e);
    bad_count++;
    $display("Error at %0t: got %h exp %h", $time, g, e);
  endtask
  // Bus cycles: strobes last one clock, read data land in the next
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_in) begin address_in <= a; write_data_in <= d; write_in <= 1'b1; end
    @(posedge clock_in) write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_in) begin address_in <= a; read_in <= 1'b1; end
    @(posedge clock_in) read_in <= 1'b0;
    #1 rdata = rdo;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  // Rotating order starting at the programmed first request
  function automatic int winner(logic [5:0] f, int s);
    if (s > 5) s = 0; // Codes six and seven start the search at request zero
    for (int k = 0; k < 6; k++) if (f[(s + k) % 6]) return (s + k) % 6;
    return 0;
  endfunction
  task summarize;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    p = $urandom(6);
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(8'hfa); `CHK(rdata, 8'h00)
    rd(8'h00); `CHK(rdata, 8'h00)
    for (int e = 0; e < 4; e++) begin // Fall then rise on lines a and b
      wr(8'hfa, {e[1:0], 6'h00}); level <= 6'h3c; idle(4); rd(8'hfa);
      `CHK(rdata, {e[1:0], 3'h0, e != 2, 1'b0, e != 1})
      wr(8'hfa, {e[1:0], 6'h00}); level <= 6'h3f; idle(4); rd(8'hfa);
      `CHK(rdata, {e[1:0], 3'h0, e[1], 1'b0, e[0]})
    end
    wr(8'hfa, 8'h00); level <= 6'h1b; idle(4); rd(8'hfa); `CHK(rdata, 8'h0a)
    rd(8'hfc); `CHK(rdata[0], 1'b1)
    wr(8'hfc, 8'h01); rd(8'hfa); `CHK(rdata, 8'h02)
    wr(8'hfa, 8'h00); level <= 6'h3f; idle(4); rd(8'hfa); `CHK(rdata, 8'h00)
    wr(8'hf0, 8'h01); level <= 6'h37; idle(4); rd(8'hfa); `CHK(rdata, 8'h04)
    wr(8'hfa, 8'h00); level <= 6'h2f; idle(4); rd(8'hfa); `CHK(rdata, 8'h01)
    wr(8'hf0, 8'h00); level <= 6'h3f; wr(8'hfa, 8'h00);
    $display("Test edges done");
    for (int i = 0; i < 14; i++) begin // Every first request, then random sets
      flags = (i < 6) ? 8'h3f : 8'($urandom_range(1, 63));
      p = (i < 6) ? i : $urandom_range(0, 7);
      wr(8'hfa, flags); wr(8'hf9, p[7:0]); wr(8'hfb, 8'h3f); idle(3);
      `CHK(cyc, 1'b0)
      wr(8'hfb, 8'hbf); #1;
      for (w = 0; w < 8 && cyc !== 1'b1; w++) idle(1);
      `CHK(cyc, 1'b1)
      `CHK(w[7:0], 8'h01)
      `CHK(vec, 8'(2 * winner(flags[5:0], p)))
      rd(8'hfb); `CHK(rdata, 8'h3f)
      rd(8'hfa); `CHK(rdata[5:0], flags[5:0] & ~(6'h01 << winner(flags[5:0], p)))
    end
    $display("Test grants done");
    wr(8'hfa, 8'h00); halt_in <= 1'b1;
    for (int t = 0; t < 2; t++) begin // Continuous then single pass per timer
      wr(8'hfb, 8'h30); wr(8'(8'hf4 - 2 * t), 8'h03); wr(8'(8'hf5 - 2 * t), 8'(5 + 2 * t));
      wr(8'hf1, t ? 8'h0c : 8'h03); idle(30); rd(8'hfa);
      `CHK(rdata[4 + t], 1'b1)
      `CHK(wake, 1'b1)
      wr(8'hfa, 8'h00); wr(8'(8'hf5 - 2 * t), 8'(4 + 2 * t));
      wr(8'hf1, t ? 8'h0c : 8'h03); idle(30); rd(8'(8'hf4 - 2 * t));
      `CHK(rdata, 8'h00)
      rd(8'hfa); `CHK(rdata[4 + t], 1'b1)
      wr(8'hf1, 8'h00); wr(8'hfa, 8'h00);
    end
    // Line a falls clock timer one: two falls take three down to one
    wr(8'hf2, 8'h03); wr(8'hf3, 8'h04); wr(8'hf1, 8'h0c);
    repeat (4) begin @(posedge clock_in) level <= level ^ 6'h01; idle(3); end
    rd(8'hf2); `CHK(rdata, 8'h01)
    // Cascade: each timer zero end steps timer one
    wr(8'hf4, 8'h01); wr(8'hf5, 8'h05); wr(8'hf1, 8'h4f); idle(20);
    rd(8'hf2); `CHK(rdata, 8'h00)
    // Divide by 64: one step needs 64 internal ticks of four clocks
    wr(8'hf1, 8'h00); wr(8'hfa, 8'h00); wr(8'hf5, 8'h00); wr(8'hf1, 8'h03); idle(250);
    rd(8'hfa); `CHK(rdata[4], 1'b0)
    idle(20); rd(8'hfa); `CHK(rdata[4], 1'b1)
    $display("Test timers done");
    summarize;
  end
  initial begin // Watchdog well past the fewer than a thousand clocks needed
    #2000000;
    bad_count++;
    summarize;
  end
endmodule // vectored_interrupt_and_timers_bench

// ===== test/vit_partner.sv
// Purpose: Pins, comparators and coprocessor request facing the block
// Assumes: Bench commands the levels, model drives them like a pad
// Notes: Idle lines rest high so that the first change is a falling edge
`timescale 1ns/100ps
module vit_partner (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [5:0] level_in, // a, b, c, comparator one, two, coprocessor
  output logic [5:0] line_out
);
  // Lines follow the command one clock later, as a synchronised pad would
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      line_out <= 6'h3f;
    end else begin
      line_out <= level_in;
    end
  end
endmodule // vit_partner

// ===== test/vit_props.sv
// Purpose: Port-level checks of the interrupt and timer block
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every instance of the top module
`timescale 1ns/100ps
module vit_props (
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [7:0] address_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] read_data_out,
  input wire logic halt_in,
  input wire logic interrupt_cycle_out,
  input wire logic [7:0] vector_address_out,
  input wire logic wake_out
);
  // One domain, so clock and reset are given once
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_cycle_one_pulse: assert property (interrupt_cycle_out |=> !interrupt_cycle_out)
    else $error("interrupt cycle longer than one clock");
  a_grant_disables: assert property ((interrupt_cycle_out && !write_in) ##1 !write_in
    |=> !interrupt_cycle_out) else $error("grant without re-enable");
  a_vector_even: assert property (interrupt_cycle_out |-> !vector_address_out[0])
    else $error("odd vector byte");
  a_vector_range: assert property (vector_address_out <= 8'h0a)
    else $error("vector beyond six requests");
  a_vector_held: assert property (!interrupt_cycle_out |-> $stable(vector_address_out))
    else $error("vector moved without grant");
  a_read_quiet: assert property (!$past(read_in) |-> read_data_out == 8'h00)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (read_in && address_in == 8'h00 |=> read_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_wake_halted: assert property (wake_out |-> $past(halt_in))
    else $error("wake while running");
endmodule // vit_props
bind vectored_interrupt_and_timers vit_props u_props (.clock_in(clock_in),
  .resetn_in(resetn_in), .address_in(address_in), .write_in(write_in), .read_in(read_in),
  .read_data_out(read_data_out), .halt_in(halt_in), .interrupt_cycle_out(interrupt_cycle_out),
  .vector_address_out(vector_address_out), .wake_out(wake_out));
